// ==== design/bank_out_defs.svh ====
// Constants for the bank output state tracker: command codes and sizes.
// Assumes commands arrive as one-cycle write strobes on the clk_sys domain.
`ifndef BANK_OUT_DEFS_SVH
`define BANK_OUT_DEFS_SVH

// Bank count and address split
`define NUM_BANKS 16
`define BANK_BITS 4
`define BLOCK_BITS 7

// Command codes (low byte of the data bus)
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_SIG 8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_SETUP_ALT 8'h10
`define CMD_BUF_PROG 8'hE8
`define CMD_BEFW_SETUP 8'h80
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_LOCK_SETUP 8'h60
`define CMD_OTP_SETUP 8'hC0
`define CMD_BLANK_SETUP 8'hBC
`define CMD_BLANK_CONFIRM 8'hCB
`define CMD_LOCK_CONFIRM 8'h01
`define CMD_LOCKDOWN_CONFIRM 8'h2F
`define CMD_SETCR_CONFIRM 8'h03

// Session end word for buffered factory writes
`define BEFW_EXIT_WORD 16'hFFFF

`endif

// ==== design/bank_out_pkg.sv ====
// Types for the bank output state tracker.
// Assumes nothing beyond the defs header.
`default_nettype none

package bank_out_pkg;
    // Data type a bank returns on reads
    typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG, MODE_QUERY} out_mode_t;

    // Front-end sequencing state
    typedef enum logic [2:0] {ST_READY, ST_LOCK_SETUP, ST_OTP_SETUP, ST_BLANK_SETUP,
                              ST_SETUP_2ND, ST_BEFW, ST_ILLEGAL} fe_state_t;

    // Command classes after decode
    typedef enum logic [2:0] {CL_OUT_ARRAY, CL_OUT_STATUS, CL_OUT_SIG, CL_OUT_QUERY,
                              CL_KEEP, CL_ILLEGAL} cmd_class_t;
endpackage : bank_out_pkg

`default_nettype wire

// ==== design/bank_mode_slot.sv ====
// One bank's output mode holder.
// Assumes the parent decides which mode and when to load it.
`include "bank_out_defs.svh"
`default_nettype none

module bank_mode_slot
    import bank_out_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Load request
    input wire logic load,
    input wire out_mode_t mode_in,
    // Held mode
    output out_mode_t mode_q
);
    // Held until the next load request for this bank
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= MODE_ARRAY;
        else if (load)
            mode_q <= mode_in; // see R3
    end

    // Without a load the mode never moves
    mode_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !load |=> $stable(mode_q)) else $error("bank mode moved without load"); // see R3
endmodule : bank_mode_slot

`default_nettype wire

// ==== design/flash_bank_output_state_tracker.sv ====
// Bank output state tracker of a banked flash command front end.
// Assumes one-cycle write strobes and reads synchronous to clk_sys.
// Contract
// R1: Output mode applies only to addressed bank.
// R2: Each bank picks array, status, signature, query.
// R3: Bank mode held until next command there.
// R4: Next state ignores bank output mode.
// R5: 60h, C0h both cycles dropped when busy.
// R6: FFFFh to other block ends factory write.
// R7: Undefined codes are classed illegal.
// R8: Other banks keep their output mode.
`include "bank_out_defs.svh"
`default_nettype none

module flash_bank_output_state_tracker
    import bank_out_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command write
    input wire logic cmd_we,
    input wire logic [15:0] cmd_data,
    input wire logic [`BANK_BITS-1:0] cmd_bank,
    input wire logic [`BLOCK_BITS-1:0] cmd_block,
    // Controller status
    input wire logic pec_busy,
    // Read side
    input wire logic [`BANK_BITS-1:0] rd_bank,
    output out_mode_t rd_mode,
    // Front end visibility
    output fe_state_t fe_state,
    output logic illegal_q,
    output logic befw_active
);
    // Front end state register
    fe_state_t state_q;
    fe_state_t state_d;
    // Start block of a factory write session
    logic [`BLOCK_BITS-1:0] befw_block_q;
    // Decoded class and second-cycle drop flag
    cmd_class_t cls;
    logic drop_2nd_q;
    logic is_exit;
    logic mode_load;
    out_mode_t mode_new;
    out_mode_t mode_arr [`NUM_BANKS];
    out_mode_t rd_mode_q;

    // Factory write exit: all-ones word at a different block
    assign is_exit = (state_q == ST_BEFW) && (cmd_data == `BEFW_EXIT_WORD)
                     && (cmd_block != befw_block_q); // see R6

    // Classify the code; unknown codes in ready or illegal state fall to illegal
    always_comb
    begin
        cls = CL_KEEP;
        if (state_q == ST_BEFW)
            cls = is_exit ? CL_OUT_ARRAY : CL_KEEP;
        else if (state_q == ST_SETUP_2ND || state_q == ST_LOCK_SETUP
                 || state_q == ST_OTP_SETUP || state_q == ST_BLANK_SETUP)
            cls = CL_OUT_STATUS; // Second cycles report status
        else
            unique case (cmd_data[7:0])
                `CMD_READ_ARRAY: cls = CL_OUT_ARRAY;
                `CMD_READ_STATUS, `CMD_CLEAR_STATUS, `CMD_PROG_SETUP, `CMD_PROG_SETUP_ALT,
                `CMD_BUF_PROG, `CMD_BEFW_SETUP, `CMD_ERASE_SETUP, `CMD_CONFIRM, `CMD_SUSPEND,
                `CMD_BLANK_SETUP: cls = CL_OUT_STATUS;
                `CMD_LOCK_SETUP, `CMD_OTP_SETUP: cls = pec_busy ? CL_KEEP : CL_OUT_STATUS; // see R5
                `CMD_READ_SIG: cls = CL_OUT_SIG;
                `CMD_READ_QUERY: cls = CL_OUT_QUERY;
                default: cls = CL_ILLEGAL; // see R7
            endcase
    end

    // Next state from current state, code, busy flag and block, never the bank mode
    always_comb
    begin
        state_d = state_q; // see R4
        // A swallowed second cycle must not move the sequencer either
        if (cmd_we && !drop_2nd_q) // see R5
        begin
            unique case (state_q)
                ST_BEFW:
                    state_d = is_exit ? ST_READY : ST_BEFW;
                ST_LOCK_SETUP, ST_OTP_SETUP, ST_BLANK_SETUP, ST_SETUP_2ND:
                    state_d = ST_READY;
                ST_READY, ST_ILLEGAL:
                begin
                    state_d = ST_READY;
                    if (cls == CL_ILLEGAL)
                        state_d = ST_ILLEGAL; // see R7
                    else if (cmd_data[7:0] == `CMD_LOCK_SETUP && !pec_busy)
                        state_d = ST_LOCK_SETUP;
                    else if (cmd_data[7:0] == `CMD_OTP_SETUP && !pec_busy)
                        state_d = ST_OTP_SETUP;
                    else if (cmd_data[7:0] == `CMD_BLANK_SETUP)
                        state_d = ST_BLANK_SETUP;
                    else if (cmd_data[7:0] == `CMD_BEFW_SETUP)
                        state_d = ST_BEFW;
                    else if (cmd_data[7:0] == `CMD_PROG_SETUP || cmd_data[7:0] == `CMD_PROG_SETUP_ALT
                             || cmd_data[7:0] == `CMD_ERASE_SETUP || cmd_data[7:0] == `CMD_BUF_PROG)
                        state_d = ST_SETUP_2ND;
                end
                default: state_d = ST_READY; // Unused codes recover
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_READY;
        else
            state_q <= state_d;
    end

    // Second cycle of a dropped setup is swallowed too
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            drop_2nd_q <= 1'b0;
        else if (cmd_we)
            drop_2nd_q <= !drop_2nd_q && (state_q == ST_READY || state_q == ST_ILLEGAL) && pec_busy
                          && (cmd_data[7:0] == `CMD_LOCK_SETUP || cmd_data[7:0] == `CMD_OTP_SETUP); // see R5
    end

    // First block of a factory write session
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            befw_block_q <= '0;
        else if (cmd_we && state_q != ST_BEFW && state_d == ST_BEFW)
            befw_block_q <= cmd_block; // see R6
    end

    // Illegal flag follows the last command
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            illegal_q <= 1'b0;
        else if (cmd_we)
            illegal_q <= (cls == CL_ILLEGAL) && !drop_2nd_q; // see R7
    end

    // Mode to load; illegal and ignored writes leave output unchanged
    always_comb
    begin
        mode_new = MODE_ARRAY;
        mode_load = cmd_we && !drop_2nd_q && cls != CL_KEEP && cls != CL_ILLEGAL;
        unique case (cls)
            CL_OUT_STATUS: mode_new = MODE_STATUS;
            CL_OUT_SIG: mode_new = MODE_SIG;
            CL_OUT_QUERY: mode_new = MODE_QUERY;
            default: mode_new = MODE_ARRAY;
        endcase
    end

    // One slot per bank; only the addressed one loads
    genvar b;
    generate
        for (b = 0; b < `NUM_BANKS; b++)
        begin : g_bank
            // Bank index at the width of the bank address
            localparam logic [`BANK_BITS-1:0] bank_id = (`BANK_BITS)'(b);
            bank_mode_slot u_slot (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .load(mode_load && cmd_bank == bank_id), // see R2, R8
                .mode_in(mode_new),
                .mode_q(mode_arr[b])
            );
        end
    endgenerate

    // Registered read mode for the bank being read
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rd_mode_q <= MODE_ARRAY;
        else
            rd_mode_q <= mode_arr[rd_bank]; // see R1
    end

    assign rd_mode = rd_mode_q;
    assign fe_state = state_q;
    assign befw_active = (state_q == ST_BEFW);

    // Read returns the mode of the bank read, one cycle on
    read_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> rd_mode == $past(mode_arr[rd_bank])) else $error("read mode not from read bank"); // see R1

    // A status-class command sets status mode at its bank
    status_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_load && cls == CL_OUT_STATUS |=> mode_arr[$past(cmd_bank)] == MODE_STATUS)
        else $error("status mode not loaded"); // see R2

    // Bank 0 untouched by a write to another bank
    other_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_we && cmd_bank != 4'h0 |=> $stable(mode_arr[0])) else $error("bank 0 changed by other write"); // see R8

    // Busy lock setup in ready stays in ready and arms the second-cycle drop
    sequence busy_setup_s;
        cmd_we && !drop_2nd_q && pec_busy && state_q == ST_READY && cmd_data[7:0] == `CMD_LOCK_SETUP;
    endsequence
    busy_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busy_setup_s |=> state_q == ST_READY && drop_2nd_q) else $error("busy setup not dropped"); // see R5

    // Exit word at a new block leaves factory write
    befw_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_we && is_exit |=> state_q == ST_READY) else $error("factory write exit missed"); // see R6

    // Same block all-ones stays in factory write
    befw_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_we && state_q == ST_BEFW && cmd_block == befw_block_q |=> state_q == ST_BEFW)
        else $error("factory write left early"); // see R6

    // Unknown code in ready raises illegal
    illegal_cls_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_we && state_q == ST_READY && cls == CL_ILLEGAL && !drop_2nd_q |=> illegal_q && state_q == ST_ILLEGAL)
        else $error("illegal code not flagged"); // see R7

    // No write, no state move
    idle_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cmd_we |=> $stable(state_q)) else $error("state moved without write"); // see R4
endmodule : flash_bank_output_state_tracker

`default_nettype wire

// ==== sim/flash_host_model.sv ====
// Host model: issues command words to the tracker as one-cycle writes.
// Assumes the tracker samples cmd_we on the rising edge of clk_sys.
`include "bank_out_defs.svh"
`default_nettype none

module flash_host_model
(
    // Clock
    input wire logic clk_sys,
    // Command write
    output var logic cmd_we,
    output var logic [15:0] cmd_data,
    output var logic [`BANK_BITS-1:0] cmd_bank,
    output var logic [`BLOCK_BITS-1:0] cmd_block
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial
    begin
        cmd_we = 1'b0;
        cmd_data = 16'h0000;
        cmd_bank = '0;
        cmd_block = '0;
    end

    // One write, entered and left at a falling edge; gap gives a slow host
    task automatic wr(input logic [15:0] d, input logic [3:0] b, input logic [6:0] blk, input int gap);
        cmd_we = 1'b1;
        cmd_data = d;
        cmd_bank = b;
        cmd_block = blk;
        @(negedge clk_sys);
        cmd_we = 1'b0;
        // Released word inverted so a stale value cannot pass for a write
        cmd_data = ~d;
        repeat (gap + 1) @(negedge clk_sys);
    endtask : wr

    // Factory write end word, sent at a chosen block
    task automatic befw_exit(input logic [3:0] b, input logic [6:0] blk);
        wr(`BEFW_EXIT_WORD, b, blk, 0);
    endtask : befw_exit
endmodule : flash_host_model

`default_nettype wire

// ==== sim/tb_flash_bank_output_state_tracker.sv ====
// Testbench for the bank output state tracker, driven by the host model.
// Assumes the package and defs header compile first.
`include "bank_out_defs.svh"
`default_nettype none

module tb_flash_bank_output_state_tracker;
    import bank_out_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset, controller status and read side
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic pec_busy = 1'b0;
    logic [3:0] rd_bank = 4'h0;
    // Command bus from the host
    logic cmd_we;
    logic [15:0] cmd_data;
    logic [3:0] cmd_bank;
    logic [6:0] cmd_block;
    // Observed outputs
    out_mode_t rd_mode;
    fe_state_t fe_state;
    logic illegal_q;
    logic befw_active;
    // Score
    int fails = 0;
    int n_compared = 0;

    always #4 clk_sys = ~clk_sys;

    flash_host_model host (.clk_sys(clk_sys), .cmd_we(cmd_we), .cmd_data(cmd_data),
        .cmd_bank(cmd_bank), .cmd_block(cmd_block));

    flash_bank_output_state_tracker DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_we(cmd_we),
        .cmd_data(cmd_data), .cmd_bank(cmd_bank), .cmd_block(cmd_block), .pec_busy(pec_busy),
        .rd_bank(rd_bank), .rd_mode(rd_mode), .fe_state(fe_state), .illegal_q(illegal_q),
        .befw_active(befw_active));

    // Compare with case equality so unknowns fail
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Read a bank's mode; rd_mode lags rd_bank by one edge
    task automatic chk(input logic [3:0] b, input out_mode_t m);
        rd_bank = b;
        @(negedge clk_sys);
        cmp(8'(rd_mode), 8'(m));
    endtask : chk

    task automatic t_modes;
        logic [7:0] codes [3] = '{8'h50, 8'hD0, 8'hB0};
        host.wr(16'h0090, 4'h3, 7'h00, 0);
        host.wr(16'h0070, 4'h5, 7'h00, 2);
        host.wr(16'h0098, 4'h7, 7'h00, 0);
        chk(4'h3, MODE_SIG);
        chk(4'h5, MODE_STATUS);
        chk(4'h7, MODE_QUERY);
        chk(4'h0, MODE_ARRAY);
        host.wr(16'h00FF, 4'h3, 7'h00, 0);
        chk(4'h3, MODE_ARRAY);
        chk(4'h7, MODE_QUERY);
        // Status-class codes 50h, D0h and B0h, each from signature mode
        foreach (codes[i])
        begin
            host.wr(16'h0090, 4'h1, 7'h00, 0);
            host.wr({8'h00, codes[i]}, 4'h1, 7'h00, 0);
            chk(4'h1, MODE_STATUS);
        end
        $display("test modes done");
    endtask : t_modes

    // Two-cycle setups end in status, each from signature mode
    task automatic t_pairs;
        logic [7:0] codes [7] = '{8'h40, 8'h10, 8'h20, 8'h60, 8'hC0, 8'hBC, 8'hE8};
        foreach (codes[i])
        begin
            host.wr(16'h0090, 4'(i + 8), 7'h00, 0);
            host.wr({8'h00, codes[i]}, 4'(i + 8), 7'h00, 0);
            host.wr(16'h0000, 4'(i + 8), 7'h00, 0);
            chk(4'(i + 8), MODE_STATUS);
            cmp(8'(fe_state), 8'(ST_READY));
        end
        $display("test pairs done");
    endtask : t_pairs

    // Lock and OTP setups dropped in both cycles while busy
    task automatic t_busy;
        logic [7:0] codes [2] = '{8'h60, 8'hC0};
        pec_busy = 1'b1;
        foreach (codes[i])
        begin
            host.wr({8'h00, codes[i]}, 4'h2, 7'h00, 0);
            cmp(8'(fe_state), 8'(ST_READY));
            host.wr(16'h0001, 4'h2, 7'h00, 0);
            cmp(8'(fe_state), 8'(ST_READY));
            cmp(8'(illegal_q), 8'h00);
            chk(4'h2, MODE_ARRAY);
        end
        pec_busy = 1'b0;
        host.wr(16'h0060, 4'h2, 7'h00, 0);
        cmp(8'(fe_state), 8'(ST_LOCK_SETUP));
        host.wr(16'h0001, 4'h2, 7'h00, 0);
        chk(4'h2, MODE_STATUS);
        $display("test busy done");
    endtask : t_busy

    task automatic t_befw;
        host.wr(16'h0080, 4'h4, 7'h05, 0);
        cmp(8'(befw_active), 8'h01);
        host.befw_exit(4'h4, 7'h05);
        cmp(8'(befw_active), 8'h01);
        host.befw_exit(4'h4, 7'h09);
        cmp(8'(befw_active), 8'h00);
        chk(4'h4, MODE_ARRAY);
        $display("test factory write done");
    endtask : t_befw

    task automatic t_illegal;
        host.wr(16'h0090, 4'h6, 7'h00, 0);
        host.wr(16'h003A, 4'h6, 7'h00, 0);
        cmp(8'(illegal_q), 8'h01);
        chk(4'h6, MODE_SIG);
        host.wr(16'h0070, 4'h6, 7'h00, 0);
        cmp(8'(illegal_q), 8'h00);
        $display("test illegal done");
    endtask : t_illegal

    // Mid-run reset returns banks 6 and 1 to array and clears the illegal flag
    task automatic t_reset;
        host.wr(16'h003A, 4'h1, 7'h00, 0);
        cmp(8'(illegal_q), 8'h01);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        cmp(8'(illegal_q), 8'h00);
        cmp(8'(fe_state), 8'(ST_READY));
        chk(4'h6, MODE_ARRAY);
        chk(4'h1, MODE_ARRAY);
        $display("test reset done");
    endtask : t_reset

    // Verdict and end of run
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_modes();
        t_pairs();
        t_busy();
        t_befw();
        t_illegal();
        t_reset();
        final_report();
    end

    // Watchdog, well past the 120 or so cycles the tests take
    initial
    begin
        #(5000 * 8);
        fails++;
        final_report();
    end
endmodule : tb_flash_bank_output_state_tracker

`default_nettype wire
